// ---- design/adc_ctrl_map.svh ----
// offsets, field positions, reset values and link constants of the status/control pair
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define DEVICE_FLAGS_ADDR    8'h00
`define MAIN_CONTROL_ADDR    8'h01
`define DEVICE_FLAGS_RESET   8'h81
`define MAIN_CONTROL_RESET   8'h00

// ----------------------------------------------------------------
// device_flags fields
// ----------------------------------------------------------------
`define FLG_FIXED_ONE        7
`define FLG_SEQ_ACTIVE       6
`define FLG_HS_MODE          5
`define FLG_AVG_DONE         3
`define FLG_CFG_ERR          2
`define FLG_CRC_ERR          1
`define FLG_BROWNOUT         0

// ----------------------------------------------------------------
// main_control fields
// ----------------------------------------------------------------
`define CTL_CRC_EN           6
`define CTL_MIN_MAX_TRACKING_ENABLE         5
`define CTL_WINDOW_EN        4
`define CTL_CONVERT          3
`define CTL_FORCE_ANALOG     2
`define CTL_OFFSET_TRIM      1
`define CTL_SOFT_RESET       0

// ----------------------------------------------------------------
// link constants
// ----------------------------------------------------------------
`define HS_MASTER_CODE       5'h01
`define I2C_ADDR_DEFAULT     7'h10
`define BITS_PER_BYTE        4'h8

`endif

// ---- design/adc_ctrl_pkg.sv ----
// types shared by the status/control block
package adc_ctrl_pkg;

    // ----------------------------------------------------------------
    // link sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [9:0] {
        ST_IDLE      = 10'h001,
        ST_ADDR      = 10'h002,
        ST_ADDR_ACK  = 10'h004,
        ST_REG       = 10'h008,
        ST_REG_ACK   = 10'h010,
        ST_WDATA     = 10'h020,
        ST_WDATA_ACK = 10'h040,
        ST_STRETCH   = 10'h080,
        ST_RDATA     = 10'h100,
        ST_RDATA_ACK = 10'h200
    } link_state_t;

endpackage

// ---- design/flag_if.sv ----
// carrier between the register bank and one sticky status flag
`timescale 1ns/1ps
interface flag_if;
    logic set;
    logic clr;
    logic init;
    logic q;
    modport owner (input set, input clr, input init, output q);
    modport user  (output set, output clr, output init, input q);
endinterface

// ---- design/sync2.sv ----
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input  logic             clk,
    input  logic             rst_n,
    input  logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // idle bus lines are high, so reset to ones
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {WIDTH{1'b1}};
            q    <= {WIDTH{1'b1}};
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ---- design/sticky_flag.sv ----
// sticky flag: hardware set wins over software clear and over soft reset
`timescale 1ns/1ps
module sticky_flag #(
    parameter logic RESET_VALUE = 1'b0
) (
    input  logic   clk,
    input  logic   rst_n,
    flag_if.owner  f
);
    logic q;

    assign f.q = q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RESET_VALUE;
        end else begin
            q <= f.set | (f.init & RESET_VALUE) | (~f.init & ~f.clr & q);
        end
    end
endmodule

// ---- design/adc_status_and_general_control.sv ----
// status and general control register pair reached over an i2c target port
//
// Operation
// (R1) flags reset to 0x81; top bit reads one.
// (R2) bit 6 reads one while the sequencer runs.
// (R3) bit 5 reads one in high-speed mode.
// (R4) averaging done flag sets on result; write one clears.
// (R5) config check error sampled only after any reset.
// (R6) inbound check error sets on failed check; write one clears.
// (R7) while check error set, writes beyond offsets 0 and 1 dropped.
// (R8) brown-out flag resets to one, sets on brown-out; write one clears.
// (R9) check enable turns on output append and incoming check.
// (R10) tracking enable clears statistics then updates them.
// (R11) window enable runs comparator; zero resets it.
// (R12) convert trigger reads zero.
// (R13) untriggered read converts at ninth fall, stretching clock until done.
// (R14) trigger write converts; the next read is not stretched.
// (R15) force bit makes every channel analog.
// (R16) trim bit starts calibration; cleared when finished.
// (R17) soft reset restores defaults, clears itself, sets brown-out flag.
// (R18) reserved and read-only bits ignore writes; reserved bits read zero.
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module adc_status_and_general_control
    import adc_ctrl_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDRESS = `I2C_ADDR_DEFAULT
) (
    input  logic core_clk,
    input  logic reset_n,
    input  logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input  logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input  logic sequencer_active,
    input  logic averaging_done,
    input  logic crc_fail,
    input  logic brownout_detect,
    input  logic config_check_fail,
    input  logic conv_done,
    input  logic cal_done,
    output logic crc_enable,
    output logic stats_enable,
    output logic stats_clear,
    output logic window_enable,
    output logic window_reset,
    output logic force_analog,
    output logic cal_start,
    output logic conv_start
);

    // ----------------------------------------------------------------
    // reset release and pin sampling
    // ----------------------------------------------------------------
    logic [1:0]  rst_pipe;
    logic        rst_n, scl_s, sda_s, scl_d, sda_d;
    logic        scl_rise, scl_fall, start_det, stop_det;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    sync2 #(.WIDTH(2)) u_pin_sync (
        .clk   (core_clk),
        .rst_n (rst_n),
        .d     ({scl_in, sda_in}),
        .q     ({scl_s, sda_s})
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end
    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    link_state_t state;
    logic [3:0]  cnt;
    logic [7:0]  sh, tx, ptr, wr_addr, wr_data;
    logic [7:0]  flags_value, control_value, rd_now;
    logic        rw, host_ack, hs_mode, wr_stb, link_conv, trig_take, trig_pending;
    logic        soft_rst, cfg_load, cfg_err, crc_en, min_max_tracking_enable, win_en, force_en;
    logic        cal_busy, wr_ok, wr_flags, wr_ctl;

    flag_if avg_f ();
    flag_if crc_f ();
    flag_if bor_f ();

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    assign wr_ok    = wr_stb & (~crc_f.q | (wr_addr == `DEVICE_FLAGS_ADDR)
                              | (wr_addr == `MAIN_CONTROL_ADDR)); // (R7)
    assign wr_flags = wr_ok & (wr_addr == `DEVICE_FLAGS_ADDR);
    assign wr_ctl   = wr_ok & (wr_addr == `MAIN_CONTROL_ADDR);

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    assign avg_f.set  = averaging_done; // (R4)
    assign avg_f.clr  = wr_flags & wr_data[`FLG_AVG_DONE]; // (R4)
    assign avg_f.init = soft_rst;
    assign crc_f.set  = crc_fail & crc_en; // (R6)
    assign crc_f.clr  = wr_flags & wr_data[`FLG_CRC_ERR]; // (R6)
    assign crc_f.init = soft_rst;
    assign bor_f.set  = brownout_detect; // (R8)
    assign bor_f.clr  = wr_flags & wr_data[`FLG_BROWNOUT]; // (R8)
    assign bor_f.init = soft_rst; // (R17)

    sticky_flag #(.RESET_VALUE(1'b0)) u_avg_flag (
        .clk   (core_clk),
        .rst_n (rst_n),
        .f     (avg_f)
    );
    sticky_flag #(.RESET_VALUE(1'b0)) u_crc_flag (
        .clk   (core_clk),
        .rst_n (rst_n),
        .f     (crc_f)
    );
    sticky_flag #(.RESET_VALUE(1'b1)) u_bor_flag (
        .clk   (core_clk),
        .rst_n (rst_n),
        .f     (bor_f)
    );

    // check result taken once per reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_load <= 1'b1;
            cfg_err  <= 1'b0;
        end else begin
            cfg_load <= soft_rst; // (R5)
            if (cfg_load) begin
                cfg_err <= config_check_fail; // (R5)
            end
        end
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= wr_ctl & wr_data[`CTL_SOFT_RESET]; // (R17)
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_en   <= 1'b0;
            min_max_tracking_enable <= 1'b0;
            win_en   <= 1'b0;
            force_en <= 1'b0;
            cal_busy <= 1'b0;
        end else if (soft_rst) begin
            crc_en   <= 1'b0; // (R17)
            min_max_tracking_enable <= 1'b0;
            win_en   <= 1'b0;
            force_en <= 1'b0;
            cal_busy <= 1'b0;
        end else begin
            if (wr_ctl) begin
                crc_en   <= wr_data[`CTL_CRC_EN]; // (R9)
                min_max_tracking_enable <= wr_data[`CTL_MIN_MAX_TRACKING_ENABLE]; // (R10)
                win_en   <= wr_data[`CTL_WINDOW_EN]; // (R11)
                force_en <= wr_data[`CTL_FORCE_ANALOG]; // (R15)
            end
            if (wr_ctl & wr_data[`CTL_OFFSET_TRIM]) begin
                cal_busy <= 1'b1; // (R16)
            end else if (cal_done) begin
                cal_busy <= 1'b0; // (R16)
            end
        end
    end

    // outputs registered, one cycle behind their bits
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_enable    <= 1'b0;
            stats_enable  <= 1'b0;
            stats_clear   <= 1'b0;
            window_enable <= 1'b0;
            window_reset  <= 1'b1;
            force_analog  <= 1'b0;
            cal_start     <= 1'b0;
            conv_start    <= 1'b0;
        end else begin
            crc_enable    <= crc_en; // (R9)
            stats_enable  <= min_max_tracking_enable; // (R10)
            stats_clear   <= wr_ctl & wr_data[`CTL_MIN_MAX_TRACKING_ENABLE] & ~min_max_tracking_enable; // (R10)
            window_enable <= win_en; // (R11)
            window_reset  <= ~win_en; // (R11)
            force_analog  <= force_en; // (R15)
            cal_start     <= wr_ctl & wr_data[`CTL_OFFSET_TRIM] & ~cal_busy; // (R16)
            conv_start    <= (wr_ctl & wr_data[`CTL_CONVERT]) | link_conv; // (R14) (R13)
        end
    end

    // a trigger excuses the next read from stretching
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_pending <= 1'b0;
        end else if (wr_ctl & wr_data[`CTL_CONVERT]) begin
            trig_pending <= 1'b1; // (R14)
        end else if (trig_take | soft_rst) begin
            trig_pending <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // read values
    // ----------------------------------------------------------------
    assign flags_value   = {1'b1, sequencer_active, hs_mode, 1'b0,
                            avg_f.q, cfg_err, crc_f.q, bor_f.q}; // (R1) (R2) (R3) (R18)
    assign control_value = {1'b0, crc_en, min_max_tracking_enable, win_en,
                            1'b0, force_en, cal_busy, 1'b0}; // (R12) (R18)
    assign rd_now = (ptr == `DEVICE_FLAGS_ADDR) ? flags_value :
                    (ptr == `MAIN_CONTROL_ADDR) ? control_value : 8'h00;

    // ----------------------------------------------------------------
    // i2c target sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            cnt       <= 4'h0;
            sh        <= 8'h00;
            tx        <= 8'h00;
            ptr       <= 8'h00;
            rw        <= 1'b0;
            host_ack  <= 1'b0;
            hs_mode   <= 1'b0;
            sda_oe_n  <= 1'b1;
            scl_oe_n  <= 1'b1;
            wr_stb    <= 1'b0;
            wr_addr   <= 8'h00;
            wr_data   <= 8'h00;
            link_conv <= 1'b0;
            trig_take <= 1'b0;
            scl_out   <= 1'b0;
            sda_out   <= 1'b0;
        end else begin
            scl_out   <= 1'b0;
            sda_out   <= 1'b0;
            wr_stb    <= 1'b0;
            link_conv <= 1'b0;
            trig_take <= 1'b0;
            if (start_det) begin
                state    <= ST_ADDR;
                cnt      <= 4'h0;
                sda_oe_n <= 1'b1;
            end else if (stop_det) begin
                state    <= ST_IDLE;
                sda_oe_n <= 1'b1;
                hs_mode  <= 1'b0; // (R3)
            end else if (state == ST_STRETCH) begin
                if (conv_done) begin
                    scl_oe_n <= 1'b1; // (R13)
                    sda_oe_n <= rd_now[7];
                    tx       <= {rd_now[6:0], 1'b0};
                    ptr      <= ptr + 8'h01;
                    cnt      <= 4'h0;
                    state    <= ST_RDATA;
                end
            end else begin
                if (scl_rise) begin
                    sh  <= {sh[6:0], sda_s};
                    cnt <= cnt + 4'h1;
                    if (state == ST_RDATA_ACK) begin
                        host_ack <= ~sda_s;
                    end
                end
                if (scl_fall) begin
                    unique case (state)
                        ST_IDLE, ST_STRETCH: begin
                        end
                        ST_ADDR: begin
                            if (cnt == `BITS_PER_BYTE) begin
                                cnt <= 4'h0;
                                if (sh[7:1] == DEVICE_ADDRESS) begin
                                    rw       <= sh[0];
                                    sda_oe_n <= 1'b0;
                                    state    <= ST_ADDR_ACK;
                                end else begin
                                    if (sh[7:3] == `HS_MASTER_CODE) begin
                                        hs_mode <= 1'b1; // (R3)
                                    end
                                    state <= ST_IDLE;
                                end
                            end
                        end
                        ST_ADDR_ACK: begin
                            cnt <= 4'h0;
                            if (!rw) begin
                                sda_oe_n <= 1'b1;
                                state    <= ST_REG;
                            end else if (trig_pending) begin
                                trig_take <= 1'b1; // (R14)
                                sda_oe_n  <= rd_now[7];
                                tx        <= {rd_now[6:0], 1'b0};
                                ptr       <= ptr + 8'h01;
                                state     <= ST_RDATA;
                            end else begin
                                link_conv <= 1'b1; // (R13)
                                scl_oe_n  <= 1'b0; // (R13)
                                sda_oe_n  <= 1'b1;
                                state     <= ST_STRETCH;
                            end
                        end
                        ST_REG: begin
                            if (cnt == `BITS_PER_BYTE) begin
                                ptr      <= sh;
                                sda_oe_n <= 1'b0;
                                state    <= ST_REG_ACK;
                            end
                        end
                        ST_REG_ACK: begin
                            cnt      <= 4'h0;
                            sda_oe_n <= 1'b1;
                            state    <= ST_WDATA;
                        end
                        ST_WDATA: begin
                            if (cnt == `BITS_PER_BYTE) begin
                                wr_stb   <= 1'b1;
                                wr_addr  <= ptr;
                                wr_data  <= sh;
                                ptr      <= ptr + 8'h01;
                                sda_oe_n <= 1'b0;
                                state    <= ST_WDATA_ACK;
                            end
                        end
                        ST_WDATA_ACK: begin
                            cnt      <= 4'h0;
                            sda_oe_n <= 1'b1;
                            state    <= ST_WDATA;
                        end
                        ST_RDATA: begin
                            if (cnt == `BITS_PER_BYTE) begin
                                sda_oe_n <= 1'b1;
                                cnt      <= 4'h0;
                                state    <= ST_RDATA_ACK;
                            end else begin
                                sda_oe_n <= tx[7];
                                tx       <= {tx[6:0], 1'b0};
                            end
                        end
                        ST_RDATA_ACK: begin
                            cnt <= 4'h0;
                            if (host_ack) begin
                                sda_oe_n <= rd_now[7];
                                tx       <= {rd_now[6:0], 1'b0};
                                ptr      <= ptr + 8'h01;
                                state    <= ST_RDATA;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    endcase
                end
            end
        end
    end

endmodule

// ---- bench/i2c_host.sv ----
// i2c host model: open-drain driver of the target's clock and data pins
`timescale 1ns/1ps
module i2c_host #(
    parameter logic [6:0] ADDR = 7'h10
) (
    input  wire logic clk,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low
);
    // ----------------------------------------------------------------
    // bit and frame tasks
    // ----------------------------------------------------------------
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic hp();
        repeat (4) @(negedge clk);
    endtask
    // bounded wait: a stuck target shows as a miss, not a hang
    task automatic rise();
        scl_low = 1'b0;
        for (int i = 0; i < 3000 && scl !== 1'b1; i++) @(negedge clk);
        hp();
    endtask
    task automatic bitx(input logic b, output logic r);
        sda_low = !b;
        hp();
        rise();
        r = sda;
        scl_low = 1'b1;
    endtask
    task automatic start();
        sda_low = 1'b0;
        hp();
        rise();
        sda_low = 1'b1;
        hp();
        scl_low = 1'b1;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        hp();
        rise();
        sda_low = 1'b0;
        hp();
    endtask
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(a, r);
    endtask
    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        logic [7:0] q;
        start();
        xfer({ADDR, 1'b0}, 1'b1, q);
        xfer(r, 1'b1, q);
        xfer(d, 1'b1, q);
        stop();
    endtask
    task automatic rd(input logic hs, input logic [7:0] r, output logic [7:0] d);
        logic [7:0] q;
        start();
        if (hs) xfer(8'h08, 1'b1, q);
        if (hs) start();
        xfer({ADDR, 1'b0}, 1'b1, q);
        xfer(r, 1'b1, q);
        start();
        xfer({ADDR, 1'b1}, 1'b1, q);
        xfer(8'hFF, 1'b1, d);
        stop();
    endtask
endmodule

// ---- bench/adc_ctrl_props.sv ----
// concurrent checks on the ports of the status/control register pair
`timescale 1ns/1ps
module adc_ctrl_props (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic scl_out,
    input wire logic scl_oe_n,
    input wire logic sda_out,
    input wire logic conv_done,
    input wire logic conv_start,
    input wire logic cal_start,
    input wire logic stats_clear,
    input wire logic stats_enable,
    input wire logic window_enable,
    input wire logic window_reset
);
    // ----------------------------------------------------------------
    // clock stretch and control outputs
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_stretch_begin;
        $fell(scl_oe_n);
    endsequence
    sequence s_conv_next;
        ##1 conv_start;
    endsequence
    sequence s_release;
        ##[1:3] scl_oe_n;
    endsequence
    a_stretch_cause: assert property (s_stretch_begin |-> s_conv_next)
        else $error("clock stretch without a conversion start");
    a_stretch_release: assert property (conv_done && !scl_oe_n |-> s_release)
        else $error("clock stretch not released after conversion end");
    a_stretch_held: assert property (!scl_oe_n && !conv_done && !$past(conv_done)
        && !$past(conv_done, 2) |=> !scl_oe_n)
        else $error("clock stretch dropped before conversion end");
    a_pins_open_drain: assert property (!scl_out && !sda_out)
        else $error("pin driven high");
    a_window_inverse: assert property (window_reset == !window_enable)
        else $error("window reset not inverse of enable");
    a_clear_then_on: assert property (stats_clear |-> ##[0:2] stats_enable)
        else $error("statistics clear without enable");
    a_clear_single: assert property (stats_clear |=> !stats_clear)
        else $error("statistics clear longer than one cycle");
    a_cal_single: assert property (cal_start |=> !cal_start)
        else $error("calibration start longer than one cycle");
    a_conv_single: assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
endmodule
bind adc_status_and_general_control adc_ctrl_props u_props (
    .core_clk(core_clk), .reset_n(reset_n), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_out(sda_out), .conv_done(conv_done), .conv_start(conv_start), .cal_start(cal_start),
    .stats_clear(stats_clear), .stats_enable(stats_enable), .window_enable(window_enable),
    .window_reset(window_reset)
);

// ---- bench/tb_adc_status_and_general_control.sv ----
// self-checking bench for the status/control register pair
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_adc_status_and_general_control;
    // ----------------------------------------------------------------
    // pins, open-drain wires, converter stand-in
    // ----------------------------------------------------------------
    logic        core_clk, reset_n, scl_low, sda_low, stretched, conv_done, cal_done;
    logic        sequencer_active, averaging_done, crc_fail, brownout_detect, config_check_fail;
    logic        scl_out, scl_oe_n, sda_out, sda_oe_n, crc_enable, stats_enable, stats_clear;
    logic        window_enable, window_reset, force_analog, cal_start, conv_start;
    logic [15:0] lf;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    wire logic   scl_w = scl_oe_n & !scl_low;
    wire logic   sda_w = sda_oe_n & !sda_low;
    adc_status_and_general_control DUT (
        .core_clk(core_clk), .reset_n(reset_n), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .sequencer_active(sequencer_active), .averaging_done(averaging_done),
        .crc_fail(crc_fail), .brownout_detect(brownout_detect),
        .config_check_fail(config_check_fail), .conv_done(conv_done), .cal_done(cal_done),
        .crc_enable(crc_enable), .stats_enable(stats_enable), .stats_clear(stats_clear),
        .window_enable(window_enable), .window_reset(window_reset),
        .force_analog(force_analog), .cal_start(cal_start), .conv_start(conv_start)
    );
    i2c_host host (.clk(core_clk), .scl(scl_w), .sda(sda_w),
        .scl_low(scl_low), .sda_low(sda_low));
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge core_clk);
        s = 1'b0;
    endtask
    task automatic rchk(input logic hs, input logic [7:0] r, input logic [7:0] e);
        logic [7:0] d;
        host.rd(hs, r, d);
        `CHK(d, e)
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = !core_clk;
    end
    // conversion end comes a random few cycles after each start
    always begin
        @(negedge core_clk);
        if (conv_start === 1'b1) begin
            repeat (3 + lf[3:0]) @(negedge core_clk);
            pulse(conv_done);
        end
    end
    always @(posedge core_clk) if (scl_oe_n === 1'b0) stretched <= 1'b1;
    // ~30 frames of ~350 cycles, wide margin
    initial begin
        #600us;
        n_mismatch++;
        results();
    end
    initial begin
        {reset_n, sequencer_active, averaging_done, crc_fail, brownout_detect} = 5'h00;
        {config_check_fail, conv_done, cal_done, stretched} = 4'h0;
        lf = 16'h9DAA;
        repeat (20) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (8) @(negedge core_clk);
        rchk(0, `DEVICE_FLAGS_ADDR, `DEVICE_FLAGS_RESET);
        rchk(0, `MAIN_CONTROL_ADDR, `MAIN_CONTROL_RESET);
        `CHK(stretched, 1'b1)
        rchk(0, 8'h05, 8'h00);
        sequencer_active = 1'b1;
        rchk(1, 8'h00, 8'hE1);
        sequencer_active = 1'b0;
        $display("test reset and live bits done");
        pulse(averaging_done);
        pulse(crc_fail);
        pulse(brownout_detect);
        rchk(0, 8'h00, 8'h89);
        host.wr(8'h00, 8'hFF);
        rchk(0, 8'h00, 8'h80);
        host.wr(8'h01, 8'h40);
        `CHK(crc_enable, 1'b1)
        pulse(crc_fail);
        rchk(0, 8'h00, 8'h82);
        host.wr(8'h01, 8'h00);
        rchk(0, 8'h01, 8'h00);
        host.wr(8'h00, 8'h02);
        rchk(0, 8'h00, 8'h80);
        $display("test sticky flags done");
        for (int i = 0; i < 3; i++) begin
            lf = nx(lf);
            host.wr(8'h01, lf[7:0] & 8'hF4);
            rchk(0, 8'h01, lf[7:0] & 8'h74);
            `CHK({crc_enable, stats_enable, window_enable, window_reset, force_analog},
                {lf[6], lf[5], lf[4], !lf[4], lf[2]})
        end
        host.wr(8'h01, 8'h0A);
        stretched = 1'b0;
        rchk(0, 8'h01, 8'h02);
        `CHK(stretched, 1'b0)
        pulse(cal_done);
        rchk(0, 8'h01, 8'h00);
        $display("test control done");
        config_check_fail = 1'b1;
        host.wr(8'h00, 8'h01);
        rchk(0, 8'h00, 8'h80);
        host.wr(8'h01, 8'h70);
        host.wr(8'h01, 8'h01);
        `CHK({crc_enable, stats_enable, window_enable}, 3'b000)
        rchk(0, 8'h01, 8'h00);
        rchk(0, 8'h00, 8'h85);
        config_check_fail = 1'b0;
        rchk(0, 8'h00, 8'h85);
        $display("test soft reset done");
        results();
    end
endmodule
